// File: logic/twm_consts.svh
`ifndef TWM_CONSTS_SVH
`define TWM_CONSTS_SVH

// Selectable serial clock rates, in kHz.
`define TWM_RATE_100_KHZ 100
`define TWM_RATE_400_KHZ 400
`define TWM_RATE_800_KHZ 800
`define TWM_RATE_1000_KHZ 1000

// Nominal rate of the shared low-power peripheral oscillator, in kHz.
`define TWM_PERIPH_OSC_KHZ 128

// Rate of the link clock that drives the bit engine, in kHz.
`define TWM_LINK_CLK_KHZ 20833

// Link cycles per quarter of a serial clock period, rounded up so that
// the serial clock never runs faster than the chosen rate.
`define TWM_QCNT(khz) \
    ((`TWM_LINK_CLK_KHZ + 4 * (khz) - 1) / (4 * (khz)))

// Reset values of the line drivers: released, output level low.
`define TWM_LINE_OE_N_RST 1'b1
`define TWM_LINE_OUT_RST 1'b0

// Core cycles that the link reset outlasts the core reset. A short core
// reset may fall between two slow link edges, so it is stretched first.
`define TWM_LK_RST_HOLD 6'h3f

// Bit position of the acknowledge slot, one past the last data bit.
`define TWM_ACK_BIT 4'h8

`endif

// File: logic/twm_pkg.sv
package twm_pkg;

    // Transfer types chosen by firmware.
    typedef enum logic [1:0] {
        TWM_MODE_WR = 2'b00,
        TWM_MODE_RD = 2'b01,
        TWM_MODE_RTW = 2'b10,
        TWM_MODE_WTR = 2'b11
    } twm_mode_type;

    // Serial clock rate codes.
    typedef enum logic [1:0] {
        TWM_RATE_100K = 2'b00,
        TWM_RATE_400K = 2'b01,
        TWM_RATE_800K = 2'b10,
        TWM_RATE_1M = 2'b11
    } twm_rate_type;

    // States of the bit engine on the link clock.
    typedef enum logic [2:0] {
        TWM_LS_IDLE = 3'b000,
        TWM_LS_START = 3'b001,
        TWM_LS_BIT = 3'b010,
        TWM_LS_RSTART = 3'b011,
        TWM_LS_STOP = 3'b100
    } twm_lstate_type;

endpackage

// File: logic/twm_sync_if.sv
`timescale 1ns/10ps

// Carries a group of asynchronous levels into a filter and back.
interface twm_sync_if #(
    parameter int W = 1
);
    logic [W-1:0] raw;
    logic [W-1:0] clean;

    modport filt (input raw, output clean);
    modport user (output raw, input clean);
endinterface

// File: logic/twm_sync3.sv
`timescale 1ns/10ps

// Three-stage synchroniser; the output follows only when the second and
// third stages agree, which also rejects a one-cycle glitch.
module twm_sync3 #(
    parameter int W = 1
) (
    // Clock and reset of the receiving domain.
    input wire logic clk,
    input wire logic rst_n,
    // Levels in and filtered levels out.
    twm_sync_if.filt sif
);

    logic [W-1:0] s1_r; // Metastability stage, read by s2_r alone.
    logic [W-1:0] s2_r; // Second stage.
    logic [W-1:0] s3_r; // Third stage.
    logic [W-1:0] clean_r; // Filtered output.

    // Shift chain; no reset, so the first stage never sees a constant load
    // that would mask the incoming level.
    always_ff @(posedge clk)
    begin
        s1_r <= sif.raw;
        s2_r <= s1_r;
        s3_r <= s2_r;
    end

    // Accept a bit only once two stages agree on it.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            clean_r <= '0;
        end
        else
        begin
            for (int i = 0; i < W; i++)
            begin
                if (s2_r[i] == s3_r[i])
                begin
                    clean_r[i] <= s3_r[i];
                end
            end
        end
    end

    assign sif.clean = clean_r;

endmodule

// File: logic/twm_master.sv
`timescale 1ns/10ps
`include "twm_consts.svh"

// How it works
// [RULE1] Only master; generates every transfer itself.
// [RULE2] No arbitration, no clock stretching waits.
// [RULE3] Rates 100, 400 and 800 kHz selectable.
// [RULE4] Extra 1 MHz rate, no guarantees.
// [RULE5] Read transfer receives one to sixteen bytes.
// [RULE6] Write transfer sends one to sixteen bytes.
// [RULE7] Read-then-write combined in one sequence.
// [RULE8] Write-then-read combined in one sequence.
// [RULE9] Hardware runs whole sequence after start.
// [RULE10] Both lines open-drain: pull low or release.
// [RULE11] Slaves answer address and acknowledge normally.
// [RULE12] Disabled means oscillator request stays low.
// [RULE13] Peripheral oscillator runs while request asserted.
// [RULE14] START, address, repeated START, then STOP.
// [RULE15] Missing acknowledge: STOP and nack flag.
module twm_master (
    // Core clock and synchronous reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Link clock from the peripheral oscillator.
    input wire logic lk_clk,
    // Firmware control.
    input wire logic enable,
    input wire logic start,
    input wire logic [1:0] mode,
    input wire logic [1:0] rate,
    input wire logic [6:0] slave_addr,
    input wire logic [3:0] wr_cnt_m1,
    input wire logic [3:0] rd_cnt_m1,
    // Write buffer fill port.
    input wire logic wr_en,
    input wire logic [3:0] wr_idx,
    input wire logic [7:0] wr_data,
    // Read buffer port.
    input wire logic [3:0] rd_idx,
    output logic [7:0] rd_data,
    // Status.
    output logic busy,
    output logic done,
    output logic nack,
    // Oscillator request.
    output logic periph_clk_req,
    // Open-drain serial lines.
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n
);

    // Quarter-period count for a rate code.
    function automatic logic [7:0] rate_qcnt(input logic [1:0] r);
        case (r)
            twm_pkg::TWM_RATE_100K: rate_qcnt = 8'(`TWM_QCNT(`TWM_RATE_100_KHZ));
            twm_pkg::TWM_RATE_400K: rate_qcnt = 8'(`TWM_QCNT(`TWM_RATE_400_KHZ));
            twm_pkg::TWM_RATE_800K: rate_qcnt = 8'(`TWM_QCNT(`TWM_RATE_800_KHZ));
            default: rate_qcnt = 8'(`TWM_QCNT(`TWM_RATE_1000_KHZ));
        endcase
    endfunction

    // True when the given phase of a mode receives.
    function automatic logic phase_rd(input logic [1:0] m, input logic p2);
        case (m)
            twm_pkg::TWM_MODE_RD: phase_rd = 1'b1;
            twm_pkg::TWM_MODE_RTW: phase_rd = !p2;
            twm_pkg::TWM_MODE_WTR: phase_rd = p2;
            default: phase_rd = 1'b0;
        endcase
    endfunction

    // ---------------- Core domain ----------------
    logic busy_r; // A transfer is in flight.
    logic done_r; // One-cycle completion pulse.
    logic nack_r; // Last transfer was not acknowledged.
    logic req_r; // Oscillator request.
    logic start_tgl_r; // Toggles once per accepted start.
    logic [1:0] mode_r; // Latched transfer type.
    logic [1:0] rate_r; // Latched rate code.
    logic [6:0] addr_r; // Latched slave address.
    logic [3:0] wcnt_r; // Latched write count minus one.
    logic [3:0] rcnt_r; // Latched read count minus one.
    logic [7:0] rd_data_r; // Registered read buffer word.
    logic [7:0] wbuf [16]; // Bytes to send; frozen while busy.
    logic done_seen_r; // Last done toggle level handled.
    logic [5:0] lk_hold_r; // Core cycles counted since reset ended.
    logic lk_go_r; // Lets the link domain leave reset.

    // ---------------- Link domain ----------------
    logic lk_rst_s1_r; // Reset synchroniser, first stage.
    logic lk_rst_n_r; // Reset for the link domain.
    twm_pkg::twm_lstate_type st_r; // Bit engine state.
    logic [1:0] ph_r; // Quarter within the serial bit.
    logic [7:0] qcnt_r; // Link cycles into the quarter.
    logic [7:0] qlim_r; // Quarter length for the running transfer.
    logic [3:0] bitn_r; // Bit of the frame, 8 is the acknowledge.
    logic [7:0] sh_r; // Shift register for both directions.
    logic [3:0] byte_r; // Byte index in the current phase.
    logic p2_r; // Second phase of a combined transfer.
    logic addr_fr_r; // Current frame is the address frame.
    logic lk_nack_r; // Nack seen during the transfer.
    logic done_tgl_r; // Toggles at the end of each transfer.
    logic start_seen_r; // Last start toggle level handled.
    logic scl_oe_n_r; // SCL released when high.
    logic sda_oe_n_r; // SDA released when high.
    logic [7:0] rbuf [16]; // Bytes received; frozen after done.

    logic tick; // Last cycle of a quarter.
    logic cur_rd; // Current phase receives.
    logic frame_last; // Current data byte ends the phase.
    logic want_low; // SDA value for the coming bit is low.
    logic en_s; // Enable in the link domain.
    logic start_s; // Start toggle in the link domain.
    logic scl_s; // Synchronised SCL.
    logic sda_s; // Synchronised SDA.
    logic done_s; // Done toggle in the core domain.

    // Pin levels and control toggles enter the link domain.
    twm_sync_if #(.W(4)) lk_sif ();
    assign lk_sif.raw = {req_r, start_tgl_r, scl_i, sda_i};
    assign {en_s, start_s, scl_s, sda_s} = lk_sif.clean;
    twm_sync3 #(.W(4)) u_lk_sync (
        .clk(lk_clk),
        .rst_n(lk_rst_n_r),
        .sif(lk_sif)
    );

    // The completion toggle returns to the core domain.
    twm_sync_if #(.W(1)) core_sif ();
    assign core_sif.raw = done_tgl_r;
    assign done_s = core_sif.clean;
    twm_sync3 #(.W(1)) u_core_sync (
        .clk(core_clk),
        .rst_n(rst_n),
        .sif(core_sif)
    );

    // Firmware interface: start only when enabled and idle; the settings
    // are latched here so the link domain reads stable words.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
            nack_r <= 1'b0;
            start_tgl_r <= 1'b0;
            done_seen_r <= 1'b0;
            mode_r <= 2'h0;
            rate_r <= 2'h0;
            addr_r <= 7'h00;
            wcnt_r <= 4'h0;
            rcnt_r <= 4'h0;
        end
        else
        begin
            done_r <= 1'b0;
            if (done_s != done_seen_r)
            begin
                // Completion: status words are stable by now.
                done_seen_r <= done_s;
                busy_r <= 1'b0;
                done_r <= busy_r;
                nack_r <= lk_nack_r; // [RULE15]
            end
            else if (!enable)
            begin
                // Disabling abandons the transfer; the link aborts too.
                busy_r <= 1'b0;
            end
            else if (start && !busy_r)
            begin
                busy_r <= 1'b1; // [RULE9]
                nack_r <= 1'b0;
                start_tgl_r <= !start_tgl_r;
                mode_r <= mode; // [RULE7] [RULE8]
                rate_r <= rate; // [RULE3] [RULE4]
                addr_r <= slave_addr;
                wcnt_r <= wr_cnt_m1; // [RULE6]
                rcnt_r <= rd_cnt_m1; // [RULE5]
            end
        end
    end

    // Oscillator request follows enable and is low whenever disabled.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            req_r <= 1'b0;
        end
        else
        begin
            req_r <= enable; // [RULE12] [RULE13]
        end
    end

    // Write buffer; writes during a transfer are ignored so the link
    // never sees a byte change under it.
    always_ff @(posedge core_clk)
    begin
        if (wr_en && !busy_r)
        begin
            wbuf[wr_idx] <= wr_data;
        end
    end

    // Read buffer word, valid while idle after a transfer.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            rd_data_r <= 8'h00;
        end
        else
        begin
            rd_data_r <= rbuf[rd_idx];
        end
    end

    // Link reset stretch: the link clock is far slower than the core, so
    // a reset of a few core cycles alone could be missed by the link.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            lk_hold_r <= 6'h00;
            lk_go_r <= 1'b0;
        end
        else
        begin
            if (lk_hold_r != `TWM_LK_RST_HOLD)
            begin
                lk_hold_r <= lk_hold_r + 6'h01;
            end
            lk_go_r <= (lk_hold_r == `TWM_LK_RST_HOLD);
        end
    end

    // Link reset: two flops, the first read only by the second.
    always_ff @(posedge lk_clk)
    begin
        lk_rst_s1_r <= lk_go_r;
        lk_rst_n_r <= lk_rst_s1_r;
    end

    // Quarter timer; the slave never holds SCL, so no waiting on it.
    assign tick = (qcnt_r == qlim_r - 8'h01); // [RULE2]
    always_ff @(posedge lk_clk)
    begin
        if (!lk_rst_n_r || st_r == twm_pkg::TWM_LS_IDLE || tick)
        begin
            qcnt_r <= 8'h00;
        end
        else
        begin
            qcnt_r <= qcnt_r + 8'h01;
        end
    end

    assign cur_rd = phase_rd(mode_r, p2_r);
    assign frame_last = (byte_r == (cur_rd ? rcnt_r : wcnt_r));
    // Data bits from the shifter, and the address frame is always sent,
    // even ahead of a read; in the ack slot acknowledge every read byte
    // but the last.
    assign want_low = (bitn_r < `TWM_ACK_BIT) ?
        ((addr_fr_r || !cur_rd) && !sh_r[7]) :
        (!addr_fr_r && cur_rd && !frame_last);

    // Bit engine: master only, every edge of SCL is made here.
    always_ff @(posedge lk_clk)
    begin
        if (!lk_rst_n_r)
        begin
            st_r <= twm_pkg::TWM_LS_IDLE;
            ph_r <= 2'h0;
            qlim_r <= 8'h01;
            bitn_r <= 4'h0;
            sh_r <= 8'h00;
            byte_r <= 4'h0;
            p2_r <= 1'b0;
            addr_fr_r <= 1'b0;
            lk_nack_r <= 1'b0;
            done_tgl_r <= 1'b0;
            start_seen_r <= 1'b0;
            scl_oe_n_r <= `TWM_LINE_OE_N_RST;
            sda_oe_n_r <= `TWM_LINE_OE_N_RST;
        end
        else if (!en_s)
        begin
            // Disabled: release both lines at once and forget any start.
            st_r <= twm_pkg::TWM_LS_IDLE;
            start_seen_r <= start_s;
            scl_oe_n_r <= 1'b1; // [RULE10]
            sda_oe_n_r <= 1'b1;
        end
        else
        begin
            case (st_r)
                twm_pkg::TWM_LS_IDLE:
                begin
                    // Begin only on a free bus with both lines high.
                    if (start_s != start_seen_r && scl_s && sda_s)
                    begin
                        start_seen_r <= start_s;
                        st_r <= twm_pkg::TWM_LS_START; // [RULE1]
                        ph_r <= 2'h0;
                        qlim_r <= rate_qcnt(rate_r); // [RULE3] [RULE4]
                        p2_r <= 1'b0;
                        lk_nack_r <= 1'b0;
                    end
                end
                twm_pkg::TWM_LS_START, twm_pkg::TWM_LS_RSTART:
                begin
                    if (tick)
                    begin
                        ph_r <= ph_r + 2'h1;
                        case (ph_r)
                            2'h0:
                            begin
                                // Plain START pulls SDA; repeat frees it.
                                sda_oe_n_r <= (st_r ==
                                    twm_pkg::TWM_LS_RSTART);
                            end
                            2'h1:
                            begin
                                scl_oe_n_r <= 1'b1;
                            end
                            2'h2:
                            begin
                                sda_oe_n_r <= 1'b0; // [RULE14]
                            end
                            default:
                            begin
                                // SCL low, then the address frame.
                                scl_oe_n_r <= 1'b0;
                                st_r <= twm_pkg::TWM_LS_BIT;
                                bitn_r <= 4'h0;
                                addr_fr_r <= 1'b1;
                                sh_r <= {addr_r, cur_rd}; // [RULE14]
                            end
                        endcase
                    end
                end
                twm_pkg::TWM_LS_BIT:
                begin
                    if (tick)
                    begin
                        ph_r <= ph_r + 2'h1;
                        case (ph_r)
                            2'h0:
                            begin
                                // Change SDA only while SCL is low.
                                sda_oe_n_r <= !want_low; // [RULE10]
                            end
                            2'h1:
                            begin
                                scl_oe_n_r <= 1'b1;
                            end
                            2'h2:
                            begin
                                // SCL high; the line settles.
                                sh_r <= sh_r;
                            end
                            default:
                            begin
                                scl_oe_n_r <= 1'b0;
                                if (bitn_r < `TWM_ACK_BIT)
                                begin
                                    sh_r <= {sh_r[6:0], sda_s};
                                    bitn_r <= bitn_r + 4'h1;
                                end
                                else if (sda_s && (addr_fr_r || !cur_rd))
                                begin
                                    // No acknowledge: abandon with STOP.
                                    lk_nack_r <= 1'b1; // [RULE15]
                                    st_r <= twm_pkg::TWM_LS_STOP;
                                end
                                else
                                begin
                                    bitn_r <= 4'h0;
                                    if (!addr_fr_r && cur_rd)
                                    begin
                                        rbuf[byte_r] <= sh_r; // [RULE5]
                                    end
                                    if (addr_fr_r)
                                    begin
                                        addr_fr_r <= 1'b0;
                                        byte_r <= 4'h0;
                                        sh_r <= wbuf[4'h0]; // [RULE6]
                                    end
                                    else if (!frame_last)
                                    begin
                                        byte_r <= byte_r + 4'h1;
                                        sh_r <= wbuf[byte_r + 4'h1];
                                    end
                                    else if (mode_r[1] && !p2_r)
                                    begin
                                        // Second phase behind a repeat.
                                        p2_r <= 1'b1; // [RULE7] [RULE8]
                                        st_r <= twm_pkg::TWM_LS_RSTART;
                                    end
                                    else
                                    begin
                                        st_r <= twm_pkg::TWM_LS_STOP;
                                    end
                                end
                            end
                        endcase
                    end
                end
                twm_pkg::TWM_LS_STOP:
                begin
                    if (tick)
                    begin
                        ph_r <= ph_r + 2'h1;
                        case (ph_r)
                            2'h0:
                            begin
                                sda_oe_n_r <= 1'b0;
                            end
                            2'h1:
                            begin
                                scl_oe_n_r <= 1'b1;
                            end
                            2'h2:
                            begin
                                sda_oe_n_r <= 1'b1; // [RULE14]
                            end
                            default:
                            begin
                                st_r <= twm_pkg::TWM_LS_IDLE;
                                done_tgl_r <= !done_tgl_r; // [RULE9]
                            end
                        endcase
                    end
                end
                default:
                begin
                    st_r <= twm_pkg::TWM_LS_IDLE;
                end
            endcase
        end
    end

    // Outputs straight from flops; line levels are always low.
    assign rd_data = rd_data_r;
    assign busy = busy_r;
    assign done = done_r;
    assign nack = nack_r;
    assign periph_clk_req = req_r;
    assign scl_o = `TWM_LINE_OUT_RST;
    assign sda_o = `TWM_LINE_OUT_RST;
    assign scl_oe_n = scl_oe_n_r;
    assign sda_oe_n = sda_oe_n_r;

    property p_req_off;
        @(posedge core_clk) disable iff (!rst_n)
        !enable |=> !periph_clk_req;
    endproperty
    a_req_off: assert property (p_req_off) // [RULE12]
        else $error("clock request high while disabled");

    property p_busy_req;
        @(posedge core_clk) disable iff (!rst_n)
        (busy_r && enable) |-> ##1 req_r;
    endproperty
    a_busy_req: assert property (p_busy_req) // [RULE13]
        else $error("transfer running without clock request");

    property p_start_cond;
        @(posedge lk_clk) disable iff (!lk_rst_n_r)
        ($fell(sda_oe_n_r) && scl_oe_n_r) |->
            (st_r == twm_pkg::TWM_LS_START ||
             st_r == twm_pkg::TWM_LS_RSTART);
    endproperty
    a_start_cond: assert property (p_start_cond) // [RULE14]
        else $error("SDA fell with SCL high outside a start");

    property p_stop_cond;
        @(posedge lk_clk) disable iff (!lk_rst_n_r)
        ($rose(sda_oe_n_r) && scl_oe_n_r) |->
            ($past(st_r) == twm_pkg::TWM_LS_STOP || !$past(en_s));
    endproperty
    a_stop_cond: assert property (p_stop_cond) // [RULE14]
        else $error("SDA rose with SCL high outside a stop");

    property p_nack_stop;
        @(posedge lk_clk) disable iff (!lk_rst_n_r)
        (en_s && st_r == twm_pkg::TWM_LS_BIT && tick && ph_r == 2'h3 &&
         bitn_r == `TWM_ACK_BIT && sda_s && (addr_fr_r || !cur_rd)) |=>
            (lk_nack_r && st_r == twm_pkg::TWM_LS_STOP);
    endproperty
    a_nack_stop: assert property (p_nack_stop) // [RULE15]
        else $error("missing acknowledge did not lead to stop");

    property p_scl_paced;
        @(posedge lk_clk) disable iff (!lk_rst_n_r)
        $changed(scl_oe_n_r) |-> ($past(tick) || !$past(en_s));
    endproperty
    a_scl_paced: assert property (p_scl_paced) // [RULE1]
        else $error("SCL moved off the quarter timer");

    property p_qcnt_range;
        @(posedge lk_clk) disable iff (!lk_rst_n_r)
        qcnt_r < qlim_r;
    endproperty
    a_qcnt_range: assert property (p_qcnt_range) // [RULE3]
        else $error("quarter counter ran past its limit");

    property p_bit_range;
        @(posedge lk_clk) disable iff (!lk_rst_n_r)
        (st_r == twm_pkg::TWM_LS_BIT) |-> (bitn_r <= `TWM_ACK_BIT);
    endproperty
    a_bit_range: assert property (p_bit_range) // [RULE9]
        else $error("frame ran past its acknowledge slot");

endmodule

// File: verif/twm_slave_model.sv
`timescale 1ns/10ps
// Slave on the wire: acks its address and written bytes; reads count up.
module twm_slave_model #(
    parameter logic [6:0] ADDR = 7'h2a
) (
    input wire logic scl,
    input wire logic sda,
    output logic sda_low
);
    int n = 0; // Bit slot within the byte.
    logic [7:0] sh, tx = 8'h5a; // Shift in, next read byte.
    logic act = 0, rd = 0, adr = 0, fst = 0, go = 0, mack = 0;
    logic [7:0] got[$]; // Bytes written to this slave.
    initial sda_low = 0;
    // START restarts address decode; STOP deselects.
    always @(negedge sda)
        if (scl)
            {n, adr, act, go, sda_low} = {32'h0, 4'h8};
    always @(posedge sda)
        if (scl)
            act = 0;
    // Sample at the rising clock; no stretching is ever done.
    always @(posedge scl)
    begin
        if (n < 8)
            sh = {sh[6:0], sda};
        if (n == 8 && act && !rd && !fst)
            got.push_back(sh);
        if (n == 8 && go)
            {mack, tx} = {!sda, tx + 8'h1};
        n = n + 1;
    end
    // Data changes only while the clock is low.
    always @(negedge scl)
    begin
        if (n == 9)
        begin
            go = act && rd && (fst || mack);
            fst = 0;
            n = 0;
        end
        if (n == 8 && adr)
        begin
            act = (sh[7:1] == ADDR);
            rd = sh[0];
            fst = 1;
            adr = 0;
        end
        sda_low = (n == 8) ? act && (fst || !rd) : go && !tx[7 - n];
    end
endmodule

// File: verif/two_wire_serial_master_test.sv
`timescale 1ns/10ps
// Runs transfers at every rate; written bytes are compared with a queue model, read bytes with a running count.
module two_wire_serial_master_test;
    logic core_clk = 0, lk_clk = 0, rst_n = 0, enable = 0, start = 0;
    logic [1:0] mode = 0, rate = 0;
    logic [6:0] slave_addr = 0;
    logic [3:0] wr_cnt_m1 = 0, rd_cnt_m1 = 0, wr_idx = 0, rd_idx = 0;
    logic wr_en = 0, sda_low;
    logic [7:0] wr_data = 0, rd_data;
    logic busy, done, nack, periph_clk_req, scl_o, scl_oe_n, sda_o, sda_oe_n;
    wire scl = scl_oe_n | scl_o; // Pull-ups give the high level.
    wire sda = (sda_oe_n | sda_o) & !sda_low;
    int n_fail = 0, tests_run = 0, rx_n = 'h5a;
    twm_master twm_master_inst (.core_clk, .rst_n, .lk_clk, .enable, .start,
        .mode, .rate, .slave_addr, .wr_cnt_m1, .rd_cnt_m1, .wr_en, .wr_idx,
        .wr_data, .rd_idx, .rd_data, .busy, .done, .nack, .periph_clk_req,
        .scl_i(scl), .scl_o, .scl_oe_n, .sda_i(sda), .sda_o, .sda_oe_n);
    twm_slave_model twm_slave_model_inst (.scl, .sda, .sda_low);
    initial forever #2.5 core_clk = ~core_clk;
    initial
    begin
        #7;
        forever #24 lk_clk = ~lk_clk;
    end
    // Inputs move a fixed 1 ns after the edge to avoid races.
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask
    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
            n_fail++;
        end
    endtask
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // One whole transfer; wc and rc are byte counts, not minus one.
    task automatic xfer(logic [1:0] md, rt, logic [6:0] ad, int wc, rc);
        logic [7:0] q[$];
        int k;
        twm_slave_model_inst.got.delete();
        for (int i = 0; i < wc; i++)
        begin
            wr_en = 1;
            wr_idx = 4'(i);
            wr_data = 8'($urandom);
            q.push_back(wr_data);
            tick();
        end
        wr_en = 0;
        {mode, rate, slave_addr} = {md, rt, ad};
        {wr_cnt_m1, rd_cnt_m1} = {4'(wc - 1), 4'(rc - 1)};
        start = 1;
        tick();
        start = 0;
        for (k = 0; k < 40000 && done !== 1'b1; k++)
            tick();
        chk("done", done, 8'h01);
        chk("nack", nack, ad != 7'h2a);
        tick();
        chk("idle", {busy, scl_oe_n, sda_oe_n}, 3'h3);
        if (ad != 7'h2a)
            return;
        chk("wcount", twm_slave_model_inst.got.size(), wc);
        foreach (q[i])
            chk("wbyte", twm_slave_model_inst.got[i], q[i]);
        for (int i = 0; i < rc; i++)
        begin
            rd_idx = 4'(i);
            tick();
            chk("rbyte", rd_data, 8'(rx_n++));
        end
    endtask
    initial
    begin
        #700000;
        n_fail++;
        complete_run();
    end
    initial
    begin
        void'($urandom(16281));
        repeat (4) tick();
        rst_n = 1;
        tick();
        chk("req_off", periph_clk_req, 0);
        enable = 1;
        repeat (120) tick();
        chk("req_on", periph_clk_req, 1);
        xfer(2'h0, 2'h0, 7'h13, 1, 0);
        xfer(2'h1, 2'h1, 7'h2a, 0, 2);
        xfer(2'h0, 2'h3, 7'h2a, 16, 0);
        xfer(2'h2, 2'h3, 7'h2a, 1, 2);
        xfer(2'h3, 2'h2, 7'h2a, 2, 2);
        enable = 0;
        repeat (2) tick();
        chk("req_dis", periph_clk_req, 0);
        complete_run();
    end
endmodule
